// [bench/llpll_core_test.sv]
// Purpose: Self-checking bench for the line-locked pixel clock loop
// Assumes: 25 MHz pixel rate, divisor 1024, line of 2048 clocks
// Notes:   Lock wait bounded; slow convergence shows as a mismatch
`default_nettype none
module llpll_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [10:0] UA [8] = '{11'h032, 11'h064, 11'h096, 11'h0FA,
                                       11'h15E, 11'h1F4, 11'h2EE, 11'h5DC};
    logic clk_i = 1'b0, rstn_i = 1'b0, wr = 1'b0, rd = 1'b0, sync, pix, smp, regen;
    logic bhi, blo, locked;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [10:0] pump;
    int n_errors = 0, compares = 0, cycles = 0;
    llpll_sync_src #(.PERIOD(2048)) u_llpll_sync_src (.clk_i(clk_i), .rstn_i(rstn_i),
        .line_sync_o(sync));
    llpll_core u_llpll_core (.clk_i(clk_i), .rstn_i(rstn_i), .line_sync_i(sync),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .pixel_tick_o(pix), .sample_tick_o(smp),
        .regenerated_line_sync_out_o(regen), .osc_band_sel_hi_o(bhi),
        .osc_band_sel_lo_o(blo), .pump_current_ua_o(pump), .locked_o(locked));
    initial forever #10 clk_i = ~clk_i;
    task automatic conclude();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard, well above the lock wait
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 95000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Tasks start and end at a falling edge
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_i);
        wr = 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        @(negedge clk_i);
        rd = 1'b0;
        @(negedge clk_i);
        cmp({3'b000, rdata}, {3'b000, exp});
    endtask
    task automatic t_reset();
        rchk(8'h01, 8'h40);
        rchk(8'h02, 8'h00);
        rchk(8'h03, 8'h28);
        rchk(8'h04, 8'h00);
        rchk(8'h36, 8'h00);
        rchk(8'h10, 8'h00);
        cmp(pump, UA[5]);
    endtask
    task automatic t_regs();
        wreg(8'h01, 8'h54);
        rchk(8'h01, 8'h54);
        wreg(8'h02, 8'hFF);
        rchk(8'h02, 8'hF0);
        wreg(8'h04, 8'hFF);
        rchk(8'h04, 8'hF8);
        wreg(8'h36, 8'h01);
        rchk(8'h36, 8'h01);
        wreg(8'h36, 8'h00);
    endtask
    task automatic t_fields();
        @(negedge clk_i);
        for (int c = 0; c < 8; c++) begin
            wreg(8'h03, {2'b00, 3'(c), 3'b000});
            repeat (2) @(negedge clk_i);
            cmp(pump, UA[c]);
        end
        for (int b = 0; b < 4; b++) begin
            wreg(8'h03, {2'(b), 6'h28});
            repeat (2) @(negedge clk_i);
            cmp({9'h000, bhi, blo}, 11'(b));
        end
        wreg(8'h03, 8'h28);
    endtask
    task automatic t_lock();
        int np, ns, nr;
        logic s_prev, r_prev;
        @(negedge clk_i);
        wreg(8'h01, 8'h40);
        @(negedge clk_i);
        wreg(8'h02, 8'h00);
        @(negedge clk_i);
        wreg(8'h04, 8'h80);
        for (int i = 0; i < 40000 && locked !== 1'b1; i++) @(negedge clk_i);
        cmp({10'h000, locked}, 11'h001);
        rchk(8'h3F, 8'h04);
        np = 0;
        ns = 0;
        nr = 0;
        @(posedge sync);
        @(negedge clk_i);
        s_prev = 1'b1;
        r_prev = regen;
        while (1) begin
            np += int'(pix);
            ns += int'(smp);
            nr += int'(regen && !r_prev);
            r_prev = regen;
            @(negedge clk_i);
            if (sync && !s_prev) break;
            s_prev = sync;
        end
        cmp({10'h000, np >= 127 && np <= 129}, 11'h001);
        cmp({10'h000, ns >= 127 && ns <= 129}, 11'h001);
        cmp(11'(nr), 11'h001);
    endtask
    initial begin
        repeat (5) @(negedge clk_i);
        rstn_i = 1'b1;
        @(negedge clk_i);
        t_reset();
        t_regs();
        t_fields();
        t_lock();
        conclude();
    end
endmodule
bind llpll_core llpll_monitor u_llpll_monitor (.clk_i(clk_i), .rstn_i(rstn_i),
    .line_sync_i(line_sync_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .pixel_tick_o(pixel_tick_o), .sample_tick_o(sample_tick_o),
    .regenerated_line_sync_out_o(regenerated_line_sync_out_o),
    .osc_band_sel_hi_o(osc_band_sel_hi_o), .osc_band_sel_lo_o(osc_band_sel_lo_o),
    .pump_current_ua_o(pump_current_ua_o), .locked_o(locked_o));
`default_nettype wire

// [bench/llpll_monitor.sv]
// Purpose: Port checker for the line-locked pixel clock loop
// Assumes: Register writes reach the outputs within two cycles
// Notes:   Reads checked two cycles on, since read data holds until the next read
`default_nettype none
module llpll_monitor (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        line_sync_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_rdata_o,
    input  wire logic        pixel_tick_o,
    input  wire logic        sample_tick_o,
    input  wire logic        regenerated_line_sync_out_o,
    input  wire logic        osc_band_sel_hi_o,
    input  wire logic        osc_band_sel_lo_o,
    input  wire logic [10:0] pump_current_ua_o,
    input  wire logic        locked_o
);
    localparam logic [10:0] UA [8] = '{11'h032, 11'h064, 11'h096, 11'h0FA,
                                       11'h15E, 11'h1F4, 11'h2EE, 11'h5DC};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic       sync_d;
    logic [3:0] since_edge;
    logic [7:0] last_osc;
    // Saturating age of the last sync edge, bounds lock changes
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_d     <= 1'b0;
            since_edge <= 4'hF;
            last_osc   <= 8'h28;
        end else begin
            sync_d     <= line_sync_i;
            since_edge <= (line_sync_i && !sync_d) ? 4'h0 :
                          (since_edge == 4'hF) ? since_edge : since_edge + 4'h1;
            if (reg_wr_i && reg_addr_i == 8'h03) last_osc <= reg_wdata_i;
        end
    end
    chk_pump_table: assert property (
        $past(reg_wr_i && reg_addr_i == 8'h03, 2) |-> pump_current_ua_o == UA[last_osc[5:3]])
        else $error("pump current does not match code");
    chk_band_bits: assert property (
        $past(reg_wr_i && reg_addr_i == 8'h03, 2)
        |-> {osc_band_sel_hi_o, osc_band_sel_lo_o} == last_osc[7:6])
        else $error("band select bits do not match code");
    chk_div_readback: assert property (
        (reg_wr_i && reg_addr_i == 8'h01) ##1 (reg_rd_i && reg_addr_i == 8'h01)
        |-> ##2 reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("divisor upper byte read back wrong");
    chk_unmapped_zero: assert property (
        reg_rd_i && reg_addr_i == 8'h10 |-> ##2 reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_lock_on_edge: assert property (
        $changed(locked_o) |-> since_edge <= 4'h3)
        else $error("lock changed away from a sync edge");
    chk_tick_single: assert property (
        pixel_tick_o |=> !pixel_tick_o)
        else $error("pixel tick wider than one cycle");
    chk_regen_on_sample: assert property (
        $changed(regenerated_line_sync_out_o) |-> sample_tick_o || $past(sample_tick_o))
        else $error("regenerated sync moved off a sample tick");
endmodule
`default_nettype wire

// [bench/llpll_sync_src.sv]
// Purpose: Line sync source standing in for the video source
// Assumes: Fixed line period in system clocks
// Notes:   Pulse stays low during reset so no edge is seen early
`default_nettype none
module llpll_sync_src #(
    parameter int PERIOD = 2048
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    output var  logic line_sync_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // Steady line rate; pulse of 32 clocks, longer than one sample tick period, so one always sees it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt         <= 0;
            line_sync_o <= 1'b0;
        end else begin
            cnt         <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            line_sync_o <= (cnt >= 1) && (cnt <= 32);
        end
    end
endmodule
`default_nettype wire

// [shared/llpll_pkg.sv]
// Purpose: Shared constants for the line-locked pixel clock loop
// Assumes: 50 MHz system clock; pixel clock modelled as a scaled tick rate
// Notes:   Register offsets, field positions, band limits and pump table
`default_nettype none
package llpll_pkg;
    localparam int          CLK_KHZ         = 50000;
    localparam int          PIX_SCALE       = 8;      // Model ticks run at pixel rate / 8
    localparam int          ACC_W           = 24;
    localparam int          DIV_W           = 12;
    localparam int          PHASE_W         = 5;
    // Loop gain: tick error times pump current, scaled up by this shift
    localparam int          GAIN_SHIFT      = 3;

    localparam logic [7:0]  OFS_DIV_UPPER   = 8'h01;
    localparam logic [7:0]  OFS_DIV_LOWER   = 8'h02;
    localparam logic [7:0]  OFS_OSC_PUMP    = 8'h03;
    localparam logic [7:0]  OFS_PHASE       = 8'h04;
    localparam logic [7:0]  OFS_GEAR        = 8'h36;
    localparam logic [7:0]  OFS_STATUS      = 8'h3F;

    localparam int          BAND_MSB        = 7;
    localparam int          BAND_LSB        = 6;
    localparam int          PUMP_MSB        = 5;
    localparam int          PUMP_LSB        = 3;
    localparam int          PHASE_LSB       = 3;
    localparam int          DIV_LOW_LSB     = 4;
    localparam int          GEAR_BIT        = 0;

    localparam logic [11:0] DIV_RESET       = 12'h0_400;
    localparam logic [11:0] DIV_MIN         = 12'h0_002;
    localparam logic [1:0]  BAND_RESET      = 2'h0;
    localparam logic [2:0]  PUMP_RESET      = 3'h5;
    localparam logic [4:0]  PHASE_RESET     = 5'h00;
    localparam logic [7:0]  RD_UNMAPPED     = 8'h00;

    // Band edges in MHz
    localparam int          F_MIN_MHZ       = 10;
    localparam int          F_GEAR_MHZ      = 18;
    localparam int          F_B01_MHZ       = 31;
    localparam int          F_B12_MHZ       = 62;
    localparam int          F_B23_MHZ       = 124;
    localparam int          F_MAX_MHZ       = 170;

    typedef enum logic [2:0] {
        LLPLL_IDLE    = 3'b001,
        LLPLL_ACQUIRE = 3'b010,
        LLPLL_LOCKED  = 3'b100
    } llpll_state_e;

    // Frequency word for a pixel rate in MHz
    function automatic logic [ACC_W-1:0] llpll_fword(input int f_mhz);
        longint num;
        num = (longint'(f_mhz) * 1000) << ACC_W;
        return ACC_W'(num / (longint'(CLK_KHZ) * PIX_SCALE));
    endfunction

    // Pump current in microamps per code
    function automatic logic [10:0] llpll_pump_ua(input logic [2:0] code);
        unique case (code)
            3'h0: return 11'h0_32;
            3'h1: return 11'h0_64;
            3'h2: return 11'h0_96;
            3'h3: return 11'h0_FA;
            3'h4: return 11'h1_5E;
            3'h5: return 11'h1_F4;
            3'h6: return 11'h2_EE;
            3'h7: return 11'h5_DC;
        endcase
    endfunction
endpackage
`default_nettype wire

// [verilog/llpll_core.sv]
// Purpose: Line-locked pixel clock loop with its register set
// Assumes: Line sync and register strobes synchronous to clk_i
// Notes:   Digital model of the analog loop; ticks stand for pixel clocks
`default_nettype none
// Overview of operation
// - Divide pixel clock, compare with sync, steer
// - Pixel clock equals sync rate times divisor
// - Range code picks one of four bands
// - Pump code selects drive current from table
// - Four settings: divisor, range, pump, phase
// - Phase in 32 steps, sync shifted too
module llpll_core
    import llpll_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       line_sync_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output var  logic [7:0] reg_rdata_o,
    output var  logic       pixel_tick_o,
    output var  logic       sample_tick_o,
    output var  logic       regenerated_line_sync_out_o,
    output var  logic       osc_band_sel_hi_o,
    output var  logic       osc_band_sel_lo_o,
    output var  logic [10:0] pump_current_ua_o,
    output var  logic       locked_o
);
    logic [DIV_W-1:0]   divisor;
    logic [1:0]         band;
    logic [2:0]         pump;
    logic [PHASE_W-1:0] phase;
    logic               gear;
    logic [ACC_W-1:0]   fword;
    logic [DIV_W-1:0]   tick_cnt;
    logic               sync_prev;
    llpll_state_e       state;
    logic               tick;
    logic               sample;

    // Register decode
    wire wr_upper = reg_wr_i && reg_addr_i == OFS_DIV_UPPER;
    wire wr_lower = reg_wr_i && reg_addr_i == OFS_DIV_LOWER;
    wire wr_osc   = reg_wr_i && reg_addr_i == OFS_OSC_PUMP;
    wire wr_phase = reg_wr_i && reg_addr_i == OFS_PHASE;
    wire wr_gear  = reg_wr_i && reg_addr_i == OFS_GEAR;

    wire [7:0] next_rdata =
        reg_addr_i == OFS_DIV_UPPER ? divisor[DIV_W-1:DIV_LOW_LSB] :
        reg_addr_i == OFS_DIV_LOWER ? {divisor[DIV_LOW_LSB-1:0], 4'h0} :
        reg_addr_i == OFS_OSC_PUMP  ? {band, pump, 3'h0} :
        reg_addr_i == OFS_PHASE     ? {phase, 3'h0} :
        reg_addr_i == OFS_GEAR      ? {7'h00, gear} :
        reg_addr_i == OFS_STATUS    ? {5'h00, state} : RD_UNMAPPED;

    // Band limits; gear bit extends the low band downward
    wire [ACC_W-1:0] band_lo =
        band == 2'h0 ? (gear ? llpll_fword(F_MIN_MHZ) : llpll_fword(F_GEAR_MHZ)) :
        band == 2'h1 ? llpll_fword(F_B01_MHZ) :
        band == 2'h2 ? llpll_fword(F_B12_MHZ) : llpll_fword(F_B23_MHZ);
    wire [ACC_W-1:0] band_hi =
        band == 2'h0 ? llpll_fword(F_B01_MHZ) :
        band == 2'h1 ? llpll_fword(F_B12_MHZ) :
        band == 2'h2 ? llpll_fword(F_B23_MHZ) : llpll_fword(F_MAX_MHZ);

    // Values below 2 would stall the divider, so they act as 2
    wire [DIV_W-1:0] div_eff  = divisor < DIV_MIN ? DIV_MIN : divisor;
    wire             sync_edge = line_sync_i && !sync_prev;
    // Ticks run at pixel rate / PIX_SCALE, so compare against scaled divisor
    wire [DIV_W-1:0] div_ticks = div_eff / DIV_W'(PIX_SCALE);

    // Phase error in ticks: positive means running fast
    wire signed [DIV_W+1:0] err =
        $signed({2'b00, tick_cnt}) - $signed({2'b00, div_ticks});
    wire signed [DIV_W+13:0] corr = err * $signed({1'b0, llpll_pump_ua(pump)});
    wire signed [ACC_W+1:0] fw_raw = $signed({2'b00, fword})
        - ($signed((ACC_W+2)'(corr)) <<< GAIN_SHIFT);
    // Steer and hold inside the chosen band
    wire [ACC_W-1:0] next_fword =
        fw_raw < $signed({2'b00, band_lo}) ? band_lo :
        fw_raw > $signed({2'b00, band_hi}) ? band_hi : fw_raw[ACC_W-1:0];
    wire err_small = err >= -2 && err <= 2;

    llpll_nco u_nco (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .fword_i  (fword),
        .phase_i  (phase),
        .tick_o   (tick),
        .sample_o (sample)
    );

    // Four software settings plus the gear bit
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            divisor <= DIV_RESET;
            band    <= BAND_RESET;
            pump    <= PUMP_RESET;
            phase   <= PHASE_RESET;
            gear    <= 1'b0;
        end else begin
            if (wr_upper) divisor[DIV_W-1:DIV_LOW_LSB] <= reg_wdata_i;
            if (wr_lower) divisor[DIV_LOW_LSB-1:0] <= reg_wdata_i[7:DIV_LOW_LSB];
            if (wr_osc) begin
                band <= reg_wdata_i[BAND_MSB:BAND_LSB];
                pump <= reg_wdata_i[PUMP_MSB:PUMP_LSB];
            end
            if (wr_phase) phase <= reg_wdata_i[7:PHASE_LSB];
            if (wr_gear) gear <= reg_wdata_i[GEAR_BIT];
        end
    end

    // Divider and phase compare on each line sync edge
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fword     <= llpll_fword(F_B01_MHZ);
            tick_cnt  <= '0;
            sync_prev <= 1'b0;
            state     <= LLPLL_IDLE;
        end else begin
            sync_prev <= line_sync_i;
            if (sync_edge) begin
                tick_cnt <= {{(DIV_W-1){1'b0}}, tick};
                if (state != LLPLL_IDLE) fword <= next_fword;
            end else if (tick && tick_cnt != {DIV_W{1'b1}}) begin
                tick_cnt <= tick_cnt + 1'b1;
            end
            unique case (state)
                LLPLL_IDLE:    if (sync_edge) state <= LLPLL_ACQUIRE;
                LLPLL_ACQUIRE: if (sync_edge && err_small) state <= LLPLL_LOCKED;
                LLPLL_LOCKED:  if (sync_edge && !err_small) state <= LLPLL_ACQUIRE;
                default:       state <= LLPLL_IDLE;
            endcase
        end
    end

    // Outputs straight from flops
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o                 <= RD_UNMAPPED;
            pixel_tick_o                <= 1'b0;
            sample_tick_o               <= 1'b0;
            regenerated_line_sync_out_o <= 1'b0;
            osc_band_sel_hi_o           <= 1'b0;
            osc_band_sel_lo_o           <= 1'b0;
            pump_current_ua_o           <= '0;
            locked_o                    <= 1'b0;
        end else begin
            if (reg_rd_i) reg_rdata_o <= next_rdata;
            pixel_tick_o  <= tick;
            sample_tick_o <= sample;
            // Sync re-timed on the shifted sample so it carries the same phase
            if (sample) regenerated_line_sync_out_o <= line_sync_i;
            osc_band_sel_hi_o <= band[1];
            osc_band_sel_lo_o <= band[0];
            pump_current_ua_o <= llpll_pump_ua(pump);
            locked_o          <= state == LLPLL_LOCKED;
        end
    end
endmodule
`default_nettype wire

// [verilog/llpll_nco.sv]
// Purpose: Phase accumulator making the pixel tick and the shifted sample tick
// Assumes: Frequency word below half the accumulator range
// Notes:   Sample tick fires when accumulator plus phase offset wraps
`default_nettype none
module llpll_nco
    import llpll_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rstn_i,
    input  wire logic [ACC_W-1:0]   fword_i,
    input  wire logic [PHASE_W-1:0] phase_i,
    output var  logic               tick_o,
    output var  logic               sample_o
);
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] shifted;
    logic [ACC_W-1:0] shifted_prev;
    wire  [ACC_W:0]   next_acc = {1'b0, acc} + {1'b0, fword_i};
    // 32 equal steps: offset is phase code in the top bits
    wire  [ACC_W-1:0] offset   = {phase_i, {(ACC_W-PHASE_W){1'b0}}};
    wire  [ACC_W-1:0] next_sh  = next_acc[ACC_W-1:0] + offset;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc          <= '0;
            shifted      <= '0;
            shifted_prev <= '0;
            tick_o       <= 1'b0;
            sample_o     <= 1'b0;
        end else begin
            acc          <= next_acc[ACC_W-1:0];
            shifted      <= next_sh;
            shifted_prev <= shifted;
            tick_o       <= next_acc[ACC_W];
            sample_o     <= next_sh < shifted;
        end
    end
endmodule
`default_nettype wire
